// >>> gpam_consts.vh
// constants for the genset protection and alarm manager
`ifndef GPAM_CONSTS_VH
`define GPAM_CONSTS_VH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define GPAM_CLK_PERIOD_NS   20
`define GPAM_TICK_PERIOD_US  1000
`define GPAM_TICK_CYCLES     ((`GPAM_TICK_PERIOD_US * 1000) / `GPAM_CLK_PERIOD_NS)
`define GPAM_ECU_TIMEOUT_MS  3000
`define GPAM_ECU_TICKS       ((`GPAM_ECU_TIMEOUT_MS * 1000) / `GPAM_TICK_PERIOD_US)
`define GPAM_SVC_CLR_MS      5000
`define GPAM_SVC_CLR_TICKS   ((`GPAM_SVC_CLR_MS * 1000) / `GPAM_TICK_PERIOD_US)
`define GPAM_HOUR_S          3600
`define GPAM_HOUR_TICKS      ((`GPAM_HOUR_S * 1000) * (1000 / `GPAM_TICK_PERIOD_US))
`define GPAM_FLASH_MS        500
`define GPAM_FLASH_TICKS     ((`GPAM_FLASH_MS * 1000) / `GPAM_TICK_PERIOD_US)
`define GPAM_OVS_PCT         112

// ------------------------------------------------------------
// fault levels
// ------------------------------------------------------------
`define GPAM_LVL_NONE        2'h0
`define GPAM_LVL_WARN        2'h1
`define GPAM_LVL_TRIP        2'h2
`define GPAM_LVL_SHUT        2'h3

// ------------------------------------------------------------
// fault indices, lower index wins a tie
// ------------------------------------------------------------
`define GPAM_F_FREQ_OVS      0
`define GPAM_F_RPM_OVS       1
`define GPAM_F_FREQ          2
`define GPAM_F_RPM           3
`define GPAM_F_VOLT          4
`define GPAM_F_BATT          5
`define GPAM_F_START         6
`define GPAM_F_ECU           7
`define GPAM_F_CHARGE        8
`define GPAM_F_VUNBAL        9
`define GPAM_F_CUNBAL        10
`define GPAM_F_OVERCUR       11
`define GPAM_F_PICKUP        12
`define GPAM_F_SERVICE       13
`define GPAM_NFAULT          14
`define GPAM_NSVC            3
`endif

// >>> gpam_top.v
// genset protection, alarm grading and service counters
// What this block does
// - shutdown fault lights alarm, releases contactor, stops engine now, drives alarm output
// - trip fault lights alarm, releases contactor, drives alarm output, stops after cooldown
// - warning lights warning lamp and drives alarm output only
// - faults accepted first come; an active level blocks new faults of same or lower level
// - mute silences alarm output; alarms stay recorded and keep inhibiting
// - latching alarms stay active after their condition goes away
// - protection disable demotes shutdown and trip faults to warnings
// - three service sets, each with hours limit, time limit and fault level
// - zero limit is unused; zero hours limit disables the set
// - expired set flashes service lamp, drives service output, raises configured fault
// - mute plus lamp test held 5 s clears service lamp and restarts periods
// - remaining service hours and time kept in non-volatile storage
// - frequency limits shut down after delay and holdoff; 12% overshoot stops at once
// - speed limits shut down after delay and holdoff; overshoot stops at once
// - any phase voltage out of limits for fail time after holdoff shuts down
// - battery voltage out of limits for delay shuts down, running or not
// - engine not running after allowed start attempts shuts down
// - with fuel on, no engine unit message for 3 s shuts down
// - low charge alternator voltage after holdoff shuts down
// - voltage or current unbalance beyond limit for fail time after holdoff faults
// - overcurrent raises programmable fault after inverse time delay, cancelled if current drops back
// - pickup speed below crank cut for loss time raises programmable fault
`timescale 1ns/1ps
`include "gpam_consts.vh"

// ------------------------------------------------------------
// delay qualifier: fires once cond has held for dly ticks
// ------------------------------------------------------------
module gpam_qual (
	input  wire        clk,
	input  wire        rst,
	input  wire        tick,
	input  wire        cond,
	input  wire [15:0] dly,
	output wire        fire
);
	reg [15:0] cnt_ff;
	reg        fire_ff;
	// count ticks while cond holds, restart when it drops
	always @(posedge clk) begin
		if (rst || !cond) begin
			cnt_ff  <= 16'h0000;
			fire_ff <= 1'b0;
		end else begin
			if (tick && cnt_ff != 16'hffff)
				cnt_ff <= cnt_ff + 16'h0001;
			fire_ff <= (cnt_ff >= dly);
		end
	end
	assign fire = fire_ff;
endmodule

// ------------------------------------------------------------
// top level
// ------------------------------------------------------------
module gpam_top #(
	parameter TICK_CYC   = `GPAM_TICK_CYCLES,
	parameter HOUR_TICKS = `GPAM_HOUR_TICKS
) (
	input  wire        CLK,
	input  wire        SYS_RST,
	input  wire        ENGINE_RUNNING,
	input  wire        FUEL_ON,
	input  wire        PROT_DISABLE,
	input  wire        LATCH_EN,
	input  wire        FAULT_RESET,
	input  wire        MUTE_KEY,
	input  wire        LAMP_TEST_KEY,
	input  wire [15:0] HOLDOFF_DLY,
	input  wire [15:0] COOLDOWN_DLY,
	input  wire [15:0] GEN_FREQ,
	input  wire [15:0] FREQ_LO_LIM,
	input  wire [15:0] FREQ_HI_LIM,
	input  wire [15:0] FREQ_DLY,
	input  wire [15:0] ENG_RPM,
	input  wire [15:0] RPM_LO_LIM,
	input  wire [15:0] RPM_HI_LIM,
	input  wire [15:0] RPM_OVS_LIM,
	input  wire [15:0] RPM_DLY,
	input  wire [47:0] PH_VOLT,
	input  wire [15:0] VOLT_LO_LIM,
	input  wire [15:0] VOLT_HI_LIM,
	input  wire [15:0] VFAIL_DLY,
	input  wire [15:0] UNBAL_LIM,
	input  wire [47:0] PH_CURR,
	input  wire [15:0] OC_LIM,
	input  wire [31:0] OC_CURVE_K,
	input  wire [15:0] BATT_VOLT,
	input  wire [15:0] BATT_LO_LIM,
	input  wire [15:0] BATT_HI_LIM,
	input  wire [15:0] BATT_DLY,
	input  wire [7:0]  START_ATTEMPTS,
	input  wire [7:0]  START_ATTEMPT_LIM,
	input  wire        ECU_MSG,
	input  wire [15:0] CHARGE_VOLT,
	input  wire [15:0] CHARGE_LIM,
	input  wire [15:0] MPU_RPM,
	input  wire [15:0] CRANK_CUT_RPM,
	input  wire [15:0] PICKUP_DLY,
	input  wire [1:0]  CUNBAL_ACT,
	input  wire [1:0]  OC_ACT,
	input  wire [1:0]  PICKUP_ACT,
	input  wire [47:0] SVC_HRS_LIM,
	input  wire [47:0] SVC_TIME_LIM,
	input  wire [5:0]  SVC_LEVEL,
	input  wire        NV_LOAD,
	input  wire [47:0] NV_HRS_IN,
	input  wire [47:0] NV_TIME_IN,
	output wire        ALARM_LED,
	output wire        WARNING_LED,
	output wire        ALARM_OUT,
	output wire        GC_RELEASE,
	output wire        ENGINE_STOP_REQ,
	output wire        GEN_INHIBIT,
	output wire        SERVICE_LED,
	output wire        SERVICE_REQ,
	output wire [13:0] FAULT_ACTIVE,
	output wire        NV_WRITE,
	output wire [47:0] NV_HRS_OUT,
	output wire [47:0] NV_TIME_OUT
);
	localparam [15:0] ECU_DLY = `GPAM_ECU_TICKS;
	localparam [15:0] CLR_DLY = `GPAM_SVC_CLR_TICKS;
	localparam [15:0] FLS_DLY = `GPAM_FLASH_TICKS;
	localparam [31:0] TCK_END = TICK_CYC - 1;
	localparam [31:0] HR_END  = HOUR_TICKS - 1;
	localparam N = `GPAM_NFAULT;

	reg [31:0]    tick_cnt_ff;
	reg           tick_ff;
	reg [N-1:0]   act_ff;
	reg [2*N-1:0] lvl_ff;
	reg           mute_ff, alarm_led_ff, warn_led_ff, alarm_out_ff, gc_rel_ff, stop_ff, inhibit_ff;
	reg [15:0]    cool_cnt_ff;
	reg [31:0]    oc_acc_ff;
	reg           oc_fire_ff;
	reg [31:0]    run_pre_ff, cal_pre_ff;
	reg [15:0]    rem_hrs_ff [0:2];
	reg [15:0]    rem_time_ff [0:2];
	reg           loaded_ff, nv_wr_ff, clr_hold_ff, svc_led_ff, svc_req_ff, flash_ff;
	reg [15:0]    flash_cnt_ff;
	wire          armed, f_freq, f_rpm, f_volt, f_batt, f_vub, f_cub, f_pkp, f_ecu, clr_fire;

	// ------------------------------------------------------------
	// common tick
	// ------------------------------------------------------------
	always @(posedge CLK) begin
		if (SYS_RST) begin
			tick_cnt_ff <= 32'h0000_0000;
			tick_ff     <= 1'b0;
		end else begin
			tick_ff     <= (tick_cnt_ff == TCK_END);
			tick_cnt_ff <= (tick_cnt_ff == TCK_END) ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
		end
	end

	// ------------------------------------------------------------
	// measurement checks
	// ------------------------------------------------------------
	// unbalance: |3*x - sum| > 3*lim avoids dividing by three
	function unbal;
		input [47:0] v;
		input [15:0] lim;
		reg   [19:0] s, x, l3;
		integer k;
		begin
			s = {4'h0, v[15:0]} + {4'h0, v[31:16]} + {4'h0, v[47:32]};
			l3 = {4'h0, lim} * 20'h00003;
			unbal = 1'b0;
			for (k = 0; k < 3; k = k + 1) begin
				x = {4'h0, v[16*k +: 16]} * 20'h00003;
				if ((x > s ? x - s : s - x) > l3)
					unbal = 1'b1;
			end
		end
	endfunction

	wire [31:0] freq_x100 = {16'h0000, GEN_FREQ} * 32'd100;
	wire [31:0] ovs_x100  = {16'h0000, FREQ_HI_LIM} * `GPAM_OVS_PCT;
	wire c_freq_ovs = freq_x100 > ovs_x100;
	wire c_rpm_ovs  = ENG_RPM > RPM_OVS_LIM;
	wire c_freq = armed && (GEN_FREQ < FREQ_LO_LIM || GEN_FREQ > FREQ_HI_LIM);
	wire c_rpm  = armed && (ENG_RPM < RPM_LO_LIM || ENG_RPM > RPM_HI_LIM);
	reg  c_volt, c_oc;
	integer p;
	// any phase out of window / any phase above overcurrent limit
	always @* begin
		c_volt = 1'b0;
		c_oc   = 1'b0;
		for (p = 0; p < 3; p = p + 1) begin
			if (PH_VOLT[16*p +: 16] < VOLT_LO_LIM || PH_VOLT[16*p +: 16] > VOLT_HI_LIM)
				c_volt = armed;
			if (PH_CURR[16*p +: 16] > OC_LIM)
				c_oc = 1'b1;
		end
	end
	wire c_batt = BATT_VOLT < BATT_LO_LIM || BATT_VOLT > BATT_HI_LIM;
	wire c_start = !ENGINE_RUNNING && START_ATTEMPT_LIM != 8'h00 && START_ATTEMPTS >= START_ATTEMPT_LIM;
	wire c_charge = armed && CHARGE_VOLT < CHARGE_LIM;
	wire c_pkp = armed && MPU_RPM < CRANK_CUT_RPM;

	// delay qualifiers, all on the common tick
	gpam_qual u_hold (.clk(CLK), .rst(SYS_RST), .tick(tick_ff), .cond(ENGINE_RUNNING), .dly(HOLDOFF_DLY), .fire(armed));
	gpam_qual u_freq (.clk(CLK), .rst(SYS_RST), .tick(tick_ff), .cond(c_freq), .dly(FREQ_DLY), .fire(f_freq));
	gpam_qual u_rpm  (.clk(CLK), .rst(SYS_RST), .tick(tick_ff), .cond(c_rpm), .dly(RPM_DLY), .fire(f_rpm));
	gpam_qual u_volt (.clk(CLK), .rst(SYS_RST), .tick(tick_ff), .cond(c_volt), .dly(VFAIL_DLY), .fire(f_volt));
	gpam_qual u_batt (.clk(CLK), .rst(SYS_RST), .tick(tick_ff), .cond(c_batt), .dly(BATT_DLY), .fire(f_batt));
	gpam_qual u_vub  (.clk(CLK), .rst(SYS_RST), .tick(tick_ff), .cond(armed && unbal(PH_VOLT, UNBAL_LIM)),
		.dly(VFAIL_DLY), .fire(f_vub));
	gpam_qual u_cub  (.clk(CLK), .rst(SYS_RST), .tick(tick_ff), .cond(armed && unbal(PH_CURR, UNBAL_LIM)),
		.dly(VFAIL_DLY), .fire(f_cub));
	gpam_qual u_pkp  (.clk(CLK), .rst(SYS_RST), .tick(tick_ff), .cond(c_pkp), .dly(PICKUP_DLY), .fire(f_pkp));
	gpam_qual u_ecu  (.clk(CLK), .rst(SYS_RST), .tick(tick_ff), .cond(FUEL_ON && !ECU_MSG), .dly(ECU_DLY),
		.fire(f_ecu));
	gpam_qual u_clr  (.clk(CLK), .rst(SYS_RST), .tick(tick_ff), .cond(MUTE_KEY && LAMP_TEST_KEY), .dly(CLR_DLY),
		.fire(clr_fire));

	// inverse_time_overcurrent_curve: integrate excess current, trip at curve constant
	wire [15:0] i_max = (PH_CURR[15:0] > PH_CURR[31:16]) ?
		((PH_CURR[15:0] > PH_CURR[47:32]) ? PH_CURR[15:0] : PH_CURR[47:32]) :
		((PH_CURR[31:16] > PH_CURR[47:32]) ? PH_CURR[31:16] : PH_CURR[47:32]);
	always @(posedge CLK) begin
		if (SYS_RST || !c_oc) begin
			oc_acc_ff  <= 32'h0000_0000;
			oc_fire_ff <= 1'b0;
		end else begin
			if (tick_ff && oc_acc_ff < OC_CURVE_K)
				oc_acc_ff <= oc_acc_ff + {16'h0000, i_max - OC_LIM};
			oc_fire_ff <= (oc_acc_ff >= OC_CURVE_K);
		end
	end

	// ------------------------------------------------------------
	// service counters
	// ------------------------------------------------------------
	wire hr_run = tick_ff && ENGINE_RUNNING && run_pre_ff == HR_END;
	wire hr_cal = tick_ff && cal_pre_ff == HR_END;
	reg  clr_pulse;
	reg  [2:0] svc_exp;
	reg  [1:0] svc_lvl;
	integer s, j;
	always @* begin
		clr_pulse = clr_fire && !clr_hold_ff;
		svc_exp = 3'h0;
		svc_lvl = `GPAM_LVL_NONE;
		for (s = 0; s < `GPAM_NSVC; s = s + 1) begin
			if (loaded_ff && SVC_HRS_LIM[16*s +: 16] != 16'h0000 &&
			    (rem_hrs_ff[s] == 16'h0000 || (SVC_TIME_LIM[16*s +: 16] != 16'h0000 && rem_time_ff[s] == 16'h0000)))
				svc_exp[s] = 1'b1;
			if (svc_exp[s] && SVC_LEVEL[2*s +: 2] > svc_lvl)
				svc_lvl = SVC_LEVEL[2*s +: 2];
		end
	end

	// remaining hours and time, reloaded from storage or restarted by the key combo
	always @(posedge CLK) begin
		if (SYS_RST) begin
			run_pre_ff  <= 32'h0000_0000;
			cal_pre_ff  <= 32'h0000_0000;
			loaded_ff   <= 1'b0;
			nv_wr_ff    <= 1'b0;
			clr_hold_ff <= 1'b0;
			for (j = 0; j < `GPAM_NSVC; j = j + 1) begin
				rem_hrs_ff[j]  <= 16'h0000;
				rem_time_ff[j] <= 16'h0000;
			end
		end else begin
			clr_hold_ff <= clr_fire;
			if (tick_ff && ENGINE_RUNNING)
				run_pre_ff <= hr_run ? 32'h0000_0000 : run_pre_ff + 32'h0000_0001;
			if (tick_ff)
				cal_pre_ff <= hr_cal ? 32'h0000_0000 : cal_pre_ff + 32'h0000_0001;
			nv_wr_ff <= loaded_ff && (hr_run || hr_cal || clr_pulse);
			if (NV_LOAD)
				loaded_ff <= 1'b1;
			for (j = 0; j < `GPAM_NSVC; j = j + 1) begin
				if (NV_LOAD) begin
					rem_hrs_ff[j]  <= NV_HRS_IN[16*j +: 16];
					rem_time_ff[j] <= NV_TIME_IN[16*j +: 16];
				end else if (clr_pulse) begin
					rem_hrs_ff[j]  <= SVC_HRS_LIM[16*j +: 16];
					rem_time_ff[j] <= SVC_TIME_LIM[16*j +: 16];
				end else begin
					if (hr_run && rem_hrs_ff[j] != 16'h0000)
						rem_hrs_ff[j] <= rem_hrs_ff[j] - 16'h0001;
					if (hr_cal && rem_time_ff[j] != 16'h0000)
						rem_time_ff[j] <= rem_time_ff[j] - 16'h0001;
				end
			end
		end
	end

	// service lamp flashing
	always @(posedge CLK) begin
		if (SYS_RST) begin
			flash_cnt_ff <= 16'h0000;
			flash_ff     <= 1'b0;
			svc_led_ff   <= 1'b0;
			svc_req_ff   <= 1'b0;
		end else begin
			if (tick_ff) begin
				flash_cnt_ff <= (flash_cnt_ff >= FLS_DLY - 16'h0001) ? 16'h0000 : flash_cnt_ff + 16'h0001;
				if (flash_cnt_ff >= FLS_DLY - 16'h0001) // half period of exactly FLS_DLY ticks
					flash_ff <= ~flash_ff;
			end
			svc_req_ff <= |svc_exp;
			svc_led_ff <= (|svc_exp) && flash_ff;
		end
	end

	// ------------------------------------------------------------
	// fault grading and acceptance
	// ------------------------------------------------------------
	reg [N-1:0]   raw;
	reg [2*N-1:0] lvl_in;
	reg [1:0]     cur_max, l;
	reg [N-1:0]   take;
	reg           found;
	integer i, m, q;
	always @* begin
		raw = {(svc_lvl != `GPAM_LVL_NONE), f_pkp, oc_fire_ff, f_cub, f_vub, c_charge, f_ecu, c_start, f_batt,
			f_volt, f_rpm, f_freq, c_rpm_ovs, c_freq_ovs};
		lvl_in = {svc_lvl, PICKUP_ACT, OC_ACT, CUNBAL_ACT, {10{`GPAM_LVL_SHUT}}};
		cur_max = `GPAM_LVL_NONE;
		take = {N{1'b0}};
		found = 1'b0;
		l = `GPAM_LVL_NONE;
		for (i = 0; i < N; i = i + 1)
			if (act_ff[i] && lvl_ff[2*i +: 2] > cur_max)
				cur_max = lvl_ff[2*i +: 2];
		for (i = 0; i < N; i = i + 1) begin
			l = lvl_in[2*i +: 2];
			if (PROT_DISABLE && l > `GPAM_LVL_WARN)
				l = `GPAM_LVL_WARN;
			lvl_in[2*i +: 2] = l;
			if (!found && raw[i] && !act_ff[i] && l > cur_max) begin
				take[i] = 1'b1;
				found = 1'b1;
			end
		end
	end

	// record faults; latched ones need the reset input once the cause is gone
	always @(posedge CLK) begin
		if (SYS_RST) begin
			act_ff <= {N{1'b0}};
			lvl_ff <= {2*N{1'b0}};
		end else begin
			for (m = 0; m < N; m = m + 1) begin
				if (take[m]) begin
					act_ff[m] <= 1'b1;
					lvl_ff[2*m +: 2] <= lvl_in[2*m +: 2];
				end else if (act_ff[m] && !raw[m] && (!LATCH_EN || FAULT_RESET))
					act_ff[m] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	reg any_shut, any_trip, any_warn;
	always @* begin
		any_shut = 1'b0;
		any_trip = 1'b0;
		any_warn = 1'b0;
		for (q = 0; q < N; q = q + 1) begin
			any_shut = any_shut | (act_ff[q] && lvl_ff[2*q +: 2] == `GPAM_LVL_SHUT);
			any_trip = any_trip | (act_ff[q] && lvl_ff[2*q +: 2] == `GPAM_LVL_TRIP);
			any_warn = any_warn | (act_ff[q] && lvl_ff[2*q +: 2] == `GPAM_LVL_WARN);
		end
	end

	always @(posedge CLK) begin
		if (SYS_RST) begin
			mute_ff      <= 1'b0;
			cool_cnt_ff  <= 16'h0000;
			alarm_led_ff <= 1'b0;
			warn_led_ff  <= 1'b0;
			alarm_out_ff <= 1'b0;
			gc_rel_ff    <= 1'b0;
			stop_ff      <= 1'b0;
			inhibit_ff   <= 1'b0;
		end else begin
			// mute holds until a new fault is accepted or no fault is active
			if (MUTE_KEY)
				mute_ff <= 1'b1;
			else if (|take || !(|act_ff))
				mute_ff <= 1'b0;
			if (!any_trip)
				cool_cnt_ff <= 16'h0000;
			else if (tick_ff && cool_cnt_ff != 16'hffff)
				cool_cnt_ff <= cool_cnt_ff + 16'h0001;
			alarm_led_ff <= any_shut || any_trip;
			warn_led_ff  <= any_warn;
			alarm_out_ff <= (|act_ff) && !mute_ff && !MUTE_KEY;
			gc_rel_ff    <= any_shut || any_trip;
			stop_ff      <= any_shut || (any_trip && cool_cnt_ff >= COOLDOWN_DLY);
			inhibit_ff   <= any_shut || any_trip;
		end
	end

	assign ALARM_LED       = alarm_led_ff;
	assign WARNING_LED     = warn_led_ff;
	assign ALARM_OUT       = alarm_out_ff;
	assign GC_RELEASE      = gc_rel_ff;
	assign ENGINE_STOP_REQ = stop_ff;
	assign GEN_INHIBIT     = inhibit_ff;
	assign SERVICE_LED     = svc_led_ff;
	assign SERVICE_REQ     = svc_req_ff;
	assign FAULT_ACTIVE    = act_ff;
	assign NV_WRITE        = nv_wr_ff;
	assign NV_HRS_OUT      = {rem_hrs_ff[2], rem_hrs_ff[1], rem_hrs_ff[0]};
	assign NV_TIME_OUT     = {rem_time_ff[2], rem_time_ff[1], rem_time_ff[0]};
endmodule

// >>> gpam_monitor.sv
// concurrent checks on the ports of the protection and alarm manager
`timescale 1ns/1ps
module gpam_monitor (
	input wire        CLK,
	input wire        SYS_RST,
	input wire        PROT_DISABLE,
	input wire        MUTE_KEY,
	input wire [15:0] GEN_FREQ,
	input wire [15:0] FREQ_HI_LIM,
	input wire        ALARM_LED,
	input wire        WARNING_LED,
	input wire        ALARM_OUT,
	input wire        GC_RELEASE,
	input wire        ENGINE_STOP_REQ,
	input wire        GEN_INHIBIT,
	input wire        SERVICE_LED,
	input wire        SERVICE_REQ,
	input wire [13:0] FAULT_ACTIVE,
	input wire        NV_WRITE
);
	default clocking mcb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// ----------------------------------------
	// output relations
	// ----------------------------------------
	reset_quiet_a: assert property (disable iff (1'b0) SYS_RST |=> !ALARM_LED && !GC_RELEASE && FAULT_ACTIVE == 14'h0)
		else $error("outputs not cleared by reset");
	stop_needs_alarm_a: assert property (ENGINE_STOP_REQ |-> ALARM_LED && GC_RELEASE)
		else $error("stop request without alarm level fault");
	release_inhibit_a: assert property (GC_RELEASE |-> GEN_INHIBIT)
		else $error("contactor released without inhibit");
	warn_only_a: assert property (WARNING_LED && !ALARM_LED |-> !GC_RELEASE && !ENGINE_STOP_REQ)
		else $error("warning acted on the genset");
	prot_demote_a: assert property (PROT_DISABLE [*3] ##0 !GEN_INHIBIT |=> !GC_RELEASE)
		else $error("fault not demoted while protections off");
	mute_silence_a: assert property (MUTE_KEY && $stable(FAULT_ACTIVE) && FAULT_ACTIVE == $past(FAULT_ACTIVE, 2)
		|=> !ALARM_OUT)
		else $error("alarm output not muted");
	alarm_cause_a: assert property ($rose(ALARM_OUT) |-> ALARM_LED || WARNING_LED)
		else $error("alarm output without fault");
	overshoot_path_a: assert property ((GEN_FREQ * 32'd100 > FREQ_HI_LIM * 32'd112) && !PROT_DISABLE
		&& FAULT_ACTIVE == 14'h0 |=> FAULT_ACTIVE[0] ##1 (ENGINE_STOP_REQ && GC_RELEASE && ALARM_LED))
		else $error("frequency overshoot not stopped at once");
	svc_lamp_a: assert property (SERVICE_LED |-> SERVICE_REQ || $past(SERVICE_REQ))
		else $error("service lamp without request");
	nv_pulse_a: assert property (NV_WRITE |=> !NV_WRITE)
		else $error("storage write longer than one cycle");
	// main scenarios
	cov_shut: cover property (ENGINE_STOP_REQ && GC_RELEASE);
	cov_warn: cover property (WARNING_LED && !ALARM_LED);
	cov_svc: cover property (SERVICE_REQ && FAULT_ACTIVE[13]);
	cov_mute: cover property (GEN_INHIBIT && !ALARM_OUT);
endmodule

bind gpam_top gpam_monitor mon_u (.*);

// >>> gpam_plant.sv
// measurement paths and engine unit message source at the far side
`timescale 1ns/1ps
module gpam_plant (
	input  wire        clk,
	input  wire [15:0] frq,
	input  wire [15:0] cur,
	input  wire [15:0] bat,
	input  wire        ecu_on,
	output wire [15:0] gen_freq,
	output wire [15:0] eng_rpm,
	output wire [47:0] ph_volt,
	output wire [47:0] ph_curr,
	output wire [15:0] batt_volt,
	output wire [15:0] charge_volt,
	output wire [15:0] mpu_rpm,
	output wire        ecu_msg
);
	reg [2:0] msg_cnt = 3'h0;
	// speed follows frequency, phases balanced
	assign gen_freq    = frq;
	assign eng_rpm     = frq * 16'h0003;
	assign ph_volt     = {3{16'h00e6}};
	assign ph_curr     = {3{cur}};
	assign batt_volt   = bat;
	assign charge_volt = 16'h000e;
	assign mpu_rpm     = eng_rpm;
	// one message every eight cycles while the unit talks
	always @(posedge clk) begin
		msg_cnt <= msg_cnt + 3'h1;
	end
	assign ecu_msg = ecu_on && (msg_cnt == 3'h0);
endmodule

// >>> gpam_top_tb.sv
// self-checking bench for the protection and alarm manager
`timescale 1ns/1ps
module gpam_top_tb;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         run = 1'b0, fuel = 1'b0, pdis = 1'b0, latch = 1'b0, frst = 1'b0, mute = 1'b0, lamp = 1'b0;
	reg         nv_load = 1'b0, ecu_on = 1'b0;
	reg  [15:0] frq = 16'h01f4, cur = 16'h0064, bat = 16'h0018;
	reg  [15:0] hold = 16'h0002, cool = 16'h0014, dly = 16'h0005, oc_lim = 16'h0096;
	reg  [15:0] flo = 16'h01c2, fhi = 16'h0226, rlo = 16'h0578, rhi = 16'h0640, rovs = 16'h06a4, ccut = 16'h0190;
	reg  [15:0] vlo = 16'h00c8, vhi = 16'h0104, blo = 16'h0012, bhi = 16'h001e, chg_lim = 16'h000a;
	reg  [7:0]  st_n = 8'h00, st_lim = 8'h00;
	reg  [31:0] oc_k = 32'h000001f4;
	reg  [47:0] svc_hl = 48'h0, nv_hrs = 48'h0;
	reg  [5:0]  svc_lvl = 6'h04;
	reg  [1:0]  oc_act = 2'h2;
	wire [15:0] gf, er, bv, cv, mr;
	wire [47:0] pv, pc, hrs_o, tim_o;
	wire        em, alarm_led, warn_led, alarm_out, gc_rel, stop, inhib, svc_led, svc_req, nvw;
	wire [13:0] fa;
	int         n_fail = 0, checks = 0, ncyc = 0, k, mlvl, nwr = 0;
	logic [13:0] mfa;
	bit         mmute;
	logic       a;

	always #10 clk = ~clk;
	gpam_plant pl_u (.clk(clk), .frq(frq), .cur(cur), .bat(bat), .ecu_on(ecu_on), .gen_freq(gf), .eng_rpm(er),
		.ph_volt(pv), .ph_curr(pc), .batt_volt(bv), .charge_volt(cv), .mpu_rpm(mr), .ecu_msg(em));
	gpam_top #(.TICK_CYC(4), .HOUR_TICKS(10)) dut_u (.CLK(clk), .SYS_RST(rst), .ENGINE_RUNNING(run),
		.FUEL_ON(fuel), .PROT_DISABLE(pdis), .LATCH_EN(latch), .FAULT_RESET(frst), .MUTE_KEY(mute),
		.LAMP_TEST_KEY(lamp), .HOLDOFF_DLY(hold), .COOLDOWN_DLY(cool), .GEN_FREQ(gf), .FREQ_LO_LIM(flo),
		.FREQ_HI_LIM(fhi), .FREQ_DLY(dly), .ENG_RPM(er), .RPM_LO_LIM(rlo), .RPM_HI_LIM(rhi),
		.RPM_OVS_LIM(rovs), .RPM_DLY(dly), .PH_VOLT(pv), .VOLT_LO_LIM(vlo), .VOLT_HI_LIM(vhi),
		.VFAIL_DLY(dly), .UNBAL_LIM(16'h0014), .PH_CURR(pc), .OC_LIM(oc_lim), .OC_CURVE_K(oc_k),
		.BATT_VOLT(bv), .BATT_LO_LIM(blo), .BATT_HI_LIM(bhi), .BATT_DLY(hold),
		.START_ATTEMPTS(st_n), .START_ATTEMPT_LIM(st_lim), .ECU_MSG(em), .CHARGE_VOLT(cv),
		.CHARGE_LIM(chg_lim), .MPU_RPM(mr), .CRANK_CUT_RPM(ccut), .PICKUP_DLY(dly), .CUNBAL_ACT(2'h1),
		.OC_ACT(oc_act), .PICKUP_ACT(2'h1), .SVC_HRS_LIM(svc_hl), .SVC_TIME_LIM(48'h0), .SVC_LEVEL(svc_lvl),
		.NV_LOAD(nv_load), .NV_HRS_IN(nv_hrs), .NV_TIME_IN(48'h0), .ALARM_LED(alarm_led),
		.WARNING_LED(warn_led), .ALARM_OUT(alarm_out), .GC_RELEASE(gc_rel), .ENGINE_STOP_REQ(stop),
		.GEN_INHIBIT(inhib), .SERVICE_LED(svc_led), .SERVICE_REQ(svc_req), .FAULT_ACTIVE(fa),
		.NV_WRITE(nvw), .NV_HRS_OUT(hrs_o), .NV_TIME_OUT(tim_o));

	// ----------------------------------------
	// reference model and compare helpers
	// ----------------------------------------
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task cmp(input logic [47:0] got, input logic [47:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// first come acceptance: only a strictly higher level gets in
	task offer(input int idx, input int lvl);
		if (lvl > mlvl) begin
			mfa[idx] = 1'b1;
			mlvl = lvl;
			mmute = 1'b0;
		end
	endtask
	task clr();
		mfa = 14'h0;
		mlvl = 0;
		mmute = 1'b0;
	endtask
	// expected {alarm lamp, release, inhibit, warning lamp, alarm out, stop}
	function logic [5:0] eo();
		if (mlvl >= 2)
			eo = {3'b111, 1'b0, !mmute, mlvl == 3};
		else
			eo = {3'b000, mlvl == 1, (mlvl == 1) && !mmute, 1'b0};
	endfunction
	task chk_all();
		cmp({alarm_led, gc_rel, inhib, warn_led, alarm_out, stop}, eo());
		cmp(fa, mfa);
	endtask
	task tdone(input string s);
		$display("test %s finished, %0d mismatches so far", s, n_fail);
	endtask
	task conclude();
		$display("comparisons %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard
	always @(posedge clk) begin
		ncyc++;
		if (nvw === 1'b1)
			nwr++;
		if (ncyc == 40000) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		void'($urandom(32'hcf3bdaf3));
		clr();
		cyc(4);
		rst = 1'b0;
		chk_all();
		// ----------------------------------------
		// shutdown, rejection, mute, release
		// ----------------------------------------
		frq = 16'h026c;
		bat = 16'h000a;
		cyc(3);
		offer(0, 3);
		cyc(20);
		offer(1, 3);
		offer(5, 3);
		chk_all();
		mute = 1'b1;
		cyc(1);
		mute = 1'b0;
		mmute = 1'b1;
		cyc(2);
		chk_all();
		frq = 16'h01f4 + 16'($urandom % 16);
		bat = 16'h0018;
		clr();
		cyc(4);
		chk_all();
		tdone("shutdown");
		// protections disabled: demoted to warning
		pdis = 1'b1;
		cyc(3);
		frq = 16'h026c;
		cyc(3);
		offer(0, 1);
		offer(1, 1);
		chk_all();
		frq = 16'h01f4 + 16'($urandom % 16);
		clr();
		cyc(4);
		pdis = 1'b0;
		cyc(3);
		chk_all();
		tdone("demote");
		// ----------------------------------------
		// load dump with cooldown, then shutdown on top
		// ----------------------------------------
		run = 1'b1;
		cyc(40);
		cur = 16'h00c8;
		k = 0;
		while (gc_rel !== 1'b1 && k < 200) begin
			cyc(1);
			k++;
		end
		offer(11, 2);
		cyc(1);
		chk_all();
		k = 0;
		while (stop !== 1'b1 && k < 200) begin
			cyc(1);
			k++;
		end
		cmp(48'(k >= 70 && k <= 86), 48'h1);
		frq = 16'h026c;
		cyc(3);
		offer(0, 3);
		chk_all();
		frq = 16'h01f4;
		cur = 16'h0064;
		run = 1'b0;
		clr();
		cyc(4);
		chk_all();
		tdone("trip");
		// latched fault outlives its cause
		latch = 1'b1;
		frq = 16'h026c;
		cyc(3);
		frq = 16'h01f4;
		offer(0, 3);
		cyc(10);
		chk_all();
		frst = 1'b1;
		cyc(1);
		frst = 1'b0;
		latch = 1'b0;
		clr();
		cyc(3);
		chk_all();
		tdone("latch");
		// fail to start, then low battery on its own
		st_lim = 8'h03;
		st_n = 8'h02;
		cyc(3);
		chk_all();
		st_n = 8'h03;
		cyc(3);
		offer(6, 3);
		chk_all();
		st_n = 8'h00;
		clr();
		bat = 16'h000a;
		cyc(3);
		chk_all();
		cyc(20);
		offer(5, 3);
		chk_all();
		bat = 16'h0018;
		clr();
		cyc(4);
		chk_all();
		tdone("start");
		// ----------------------------------------
		// engine unit silence with fuel on
		// ----------------------------------------
		ecu_on = 1'b1;
		fuel = 1'b1;
		cyc(200);
		chk_all();
		ecu_on = 1'b0;
		cyc(11800);
		chk_all();
		cyc(600);
		offer(7, 3);
		chk_all();
		fuel = 1'b0;
		ecu_on = 1'b1;
		clr();
		cyc(6);
		chk_all();
		tdone("ecu");
		// ----------------------------------------
		// service sets: zero limits idle, set one expires
		// ----------------------------------------
		svc_hl = {16'h0000, 16'h0003, 16'h0000};
		nv_hrs = {16'h0000, 16'h0002, 16'h0000};
		cmp(48'(nwr), 48'h0);
		nv_load = 1'b1;
		cyc(1);
		nv_load = 1'b0;
		run = 1'b1;
		cyc(20);
		cmp(svc_req, 1'b0);
		k = 0;
		while (svc_req !== 1'b1 && k < 200) begin
			cyc(1);
			k++;
		end
		run = 1'b0;
		cyc(3);
		offer(13, 1);
		chk_all();
		mute = 1'b1;
		lamp = 1'b1;
		mmute = 1'b1;
		cyc(16000);
		a = svc_led;
		cyc(2000);
		cmp(48'(a !== 1'bx && svc_led === !a), 48'h1);
		cmp(svc_req, 1'b1);
		cyc(2200);
		mute = 1'b0;
		lamp = 1'b0;
		cyc(3);
		cmp(svc_req, 1'b0);
		cmp(hrs_o[31:16], 16'h0003);
		cmp(tim_o, 48'h0);
		cmp(48'(nwr > 1), 48'h1);
		clr();
		chk_all();
		tdone("service");
		conclude();
	end
endmodule
